// ===== inc/pdur_consts.svh
// Constants of the power-down and update register block
`ifndef PDUR_CONSTS_SVH
`define PDUR_CONSTS_SVH

// ****************************************************************
// Register addresses on the serial control port
// ****************************************************************
`define PDUR_ADDR_W             13
`define PDUR_ADDR_POWER_CONTROL 13'h230
`define PDUR_ADDR_REG_UPDATE    13'h232

// ****************************************************************
// Field positions
// ****************************************************************
`define PDUR_BIT_PD_PLL         0
`define PDUR_BIT_PD_DIST_REF    1
`define PDUR_BIT_PD_OUT_DIV     2
`define PDUR_BIT_PD_CLK_IN      3
`define PDUR_BIT_PD_DIST_ALL    4
`define PDUR_PD_W               5
`define PDUR_BIT_UPDATE         0

// ****************************************************************
// Reset values
// ****************************************************************
`define PDUR_RST_POWER_CONTROL  5'h00
`define PDUR_RST_UPDATE         1'h0

// ****************************************************************
// Serial frame layout
// ****************************************************************
`define PDUR_INSTR_BITS         16
`define PDUR_DATA_BITS          8
`define PDUR_INSTR_LAST         5'h0f
`define PDUR_DATA_LAST          5'h07
`define PDUR_INSTR_RNW_BIT      15

`endif

// ===== inc/pdur_pkg.sv
// Types of the power-down and update register block
package pdur_pkg;

    // Serial frame phases
    typedef enum logic [1:0] {
        PDUR_ST_INSTR,
        PDUR_ST_DATA,
        PDUR_ST_DONE
    } pdur_state_t;

endpackage

// ===== inc/pdur_reg_if.sv
// Link between the serial engine and the register bank
`timescale 1ns/100ps

interface pdur_reg_if;
    logic        sclk_rise;   // One-cycle pulse per serial clock rising edge
    logic        wr_stb;      // One-cycle write pulse
    logic [12:0] addr;        // Register address of the frame
    logic [7:0]  wr_data;     // Write data, valid with wr_stb
    logic [7:0]  rd_data;     // Read data for addr

    modport engine
    (
        output sclk_rise,
        output wr_stb,
        output addr,
        output wr_data,
        input  rd_data
    );

    modport bank
    (
        input  sclk_rise,
        input  wr_stb,
        input  addr,
        input  wr_data,
        output rd_data
    );
endinterface

// ===== hw/pdur_regs.sv
// Buffered and active power-down registers with the update strobe
`timescale 1ns/100ps
`include "pdur_consts.svh"

module pdur_regs
(
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    // Engine side
    pdur_reg_if.bank                   rif,
    // Active configuration
    output logic [`PDUR_PD_W-1:0]      active_pd,
    output logic                       update_pending
);

    logic [`PDUR_PD_W-1:0] buffer_pd;
    logic                  wr_pc;
    logic                  wr_upd;

    // Address match
    function automatic logic hit(input logic [12:0] a, input logic [12:0] ref_a);
        hit = (a == ref_a);
    endfunction

    assign wr_pc  = rif.wr_stb & hit(rif.addr, `PDUR_ADDR_POWER_CONTROL);
    assign wr_upd = rif.wr_stb & hit(rif.addr, `PDUR_ADDR_REG_UPDATE)
                    & rif.wr_data[`PDUR_BIT_UPDATE];

    // Buffer register takes serial writes, bits 7 to 5 dropped
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            buffer_pd <= `PDUR_RST_POWER_CONTROL;
        else if (wr_pc)
            buffer_pd <= rif.wr_data[`PDUR_PD_W-1:0];
    end

    // Update strobe: set by write, cleared by the copy, set wins
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            update_pending <= `PDUR_RST_UPDATE;
        else if (wr_upd)
            update_pending <= 1'b1;
        else if (rif.sclk_rise)
            update_pending <= 1'b0;
    end

    // Copy buffer to active on the first serial clock rise after the strobe
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            active_pd <= `PDUR_RST_POWER_CONTROL;
        else if (update_pending && rif.sclk_rise)
            active_pd <= buffer_pd;
    end

    // Readback of buffer image and pending strobe
    always_comb
    begin
        rif.rd_data = 8'h00;
        if (hit(rif.addr, `PDUR_ADDR_POWER_CONTROL))
            rif.rd_data = {3'h0, buffer_pd};
        else if (hit(rif.addr, `PDUR_ADDR_REG_UPDATE))
            rif.rd_data = {7'h00, update_pending};
    end

endmodule

// ===== hw/pdur_top.sv
// Serial control port and power-down controls of the clock generator
//
// Contract
// - Power control bit 4 set to 1 powers down the whole output distribution, reset 0.
// - Power control bit 3 set to 1 powers down the distribution clock input, reset 0.
// - Power control bit 2 set to 1 powers down the output divider, reset 0.
// - Power control bit 1 set to 1 powers down the distribution reference, reset 0.
// - Writing 1 to update bit 0 copies all buffered values into the active registers.
// - The copy happens on the first serial clock rising edge after the strobe write.
// - The update bit clears itself after the copy.
`timescale 1ns/100ps
`include "pdur_consts.svh"

module pdur_top
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // Serial control port
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic sdi,
    output logic      sdo,
    output logic      sdo_oe,
    // Power-down controls, from active registers
    output logic      pd_dist_all,
    output logic      pd_clk_in,
    output logic      pd_out_div,
    output logic      pd_dist_ref,
    output logic      pd_pll,
    // Status
    output logic      update_pending
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic                 sclk_q1;
    logic                 sclk_q2;
    logic                 sclk_q3;
    logic                 cs_n_q1;
    logic                 cs_n_q2;
    logic                 sdi_q1;
    logic                 sdi_q2;
    logic                 sclk_fall;
    logic                 frame_on;
    pdur_reg_if           rif ();

    // Two flops per pin, third sclk flop for edge detection
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            sclk_q1 <= 1'b0;
            sclk_q2 <= 1'b0;
            sclk_q3 <= 1'b0;
            cs_n_q1 <= 1'b1;
            cs_n_q2 <= 1'b1;
            sdi_q1  <= 1'b0;
            sdi_q2  <= 1'b0;
        end
        else
        begin
            sclk_q1 <= sclk;
            sclk_q2 <= sclk_q1;
            sclk_q3 <= sclk_q2;
            cs_n_q1 <= cs_n;
            cs_n_q2 <= cs_n_q1;
            sdi_q1  <= sdi;
            sdi_q2  <= sdi_q1;
        end
    end

    // Edge pulses of the serial clock
    assign rif.sclk_rise = sclk_q2 & ~sclk_q3;
    assign sclk_fall     = ~sclk_q2 & sclk_q3;
    assign frame_on      = ~cs_n_q2;

    // ****************************************************************
    // Frame engine
    // ****************************************************************
    pdur_pkg::pdur_state_t          state;
    logic [`PDUR_INSTR_BITS-1:0]    shreg;
    logic [4:0]                     bit_cnt;
    logic                           rnw;
    logic                           load_rd;
    logic [`PDUR_DATA_BITS-1:0]     out_sr;
    logic [`PDUR_INSTR_BITS-1:0]    next_shreg;

    assign next_shreg = {shreg[`PDUR_INSTR_BITS-2:0], sdi_q2};

    // Frame phase, bit counter and instruction capture
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state    <= pdur_pkg::PDUR_ST_INSTR;
            bit_cnt  <= 5'h00;
            shreg    <= 16'h0000;
            rnw      <= 1'b0;
            rif.addr <= 13'h0000;
        end
        else if (!frame_on)
        begin
            state   <= pdur_pkg::PDUR_ST_INSTR;
            bit_cnt <= 5'h00;
        end
        else if (rif.sclk_rise)
        begin
            shreg <= next_shreg;
            case (state)
                pdur_pkg::PDUR_ST_INSTR:
                begin
                    if (bit_cnt == `PDUR_INSTR_LAST)
                    begin
                        rnw      <= next_shreg[`PDUR_INSTR_RNW_BIT];
                        rif.addr <= next_shreg[`PDUR_ADDR_W-1:0];
                        state    <= pdur_pkg::PDUR_ST_DATA;
                        bit_cnt  <= 5'h00;
                    end
                    else
                        bit_cnt <= bit_cnt + 5'h01;
                end
                pdur_pkg::PDUR_ST_DATA:
                begin
                    if (bit_cnt == `PDUR_DATA_LAST)
                        state <= pdur_pkg::PDUR_ST_DONE;
                    else
                        bit_cnt <= bit_cnt + 5'h01;
                end
                pdur_pkg::PDUR_ST_DONE:
                    state <= pdur_pkg::PDUR_ST_DONE;
                default:
                    state <= pdur_pkg::PDUR_ST_INSTR;
            endcase
        end
    end

    // Write pulse after the last data bit; power control data lands in buffer only
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rif.wr_stb  <= 1'b0;
            rif.wr_data <= 8'h00;
        end
        else
        begin
            rif.wr_stb <= frame_on && rif.sclk_rise && !rnw
                          && state == pdur_pkg::PDUR_ST_DATA
                          && bit_cnt == `PDUR_DATA_LAST;
            if (frame_on && rif.sclk_rise && state == pdur_pkg::PDUR_ST_DATA
                && bit_cnt == `PDUR_DATA_LAST)
                rif.wr_data <= next_shreg[`PDUR_DATA_BITS-1:0];
        end
    end

    // ****************************************************************
    // Read data output
    // ****************************************************************
    // Load readback one cycle after address capture, shift on falls
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            load_rd <= 1'b0;
            out_sr  <= 8'h00;
        end
        else
        begin
            load_rd <= frame_on && rif.sclk_rise
                       && state == pdur_pkg::PDUR_ST_INSTR
                       && bit_cnt == `PDUR_INSTR_LAST;
            if (load_rd)
                out_sr <= rif.rd_data;
            else if (frame_on && sclk_fall && state == pdur_pkg::PDUR_ST_DATA
                     && bit_cnt != 5'h00)
                out_sr <= {out_sr[`PDUR_DATA_BITS-2:0], 1'b0};
        end
    end

    // Drive the data pin only during the data phase of a read
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            sdo_oe <= 1'b0;
        else
            sdo_oe <= frame_on && rnw && state == pdur_pkg::PDUR_ST_DATA;
    end

    assign sdo = out_sr[`PDUR_DATA_BITS-1];

    // ****************************************************************
    // Register bank
    // ****************************************************************
    logic [`PDUR_PD_W-1:0] active_pd;

    pdur_regs u_regs
    (
        .clk_sys        (clk_sys),
        .resetn         (resetn),
        .rif            (rif),
        .active_pd      (active_pd),
        .update_pending (update_pending)
    );

    // Power-down controls from the active image
    assign pd_dist_all = active_pd[`PDUR_BIT_PD_DIST_ALL];
    assign pd_clk_in   = active_pd[`PDUR_BIT_PD_CLK_IN];
    assign pd_out_div  = active_pd[`PDUR_BIT_PD_OUT_DIV];
    assign pd_dist_ref = active_pd[`PDUR_BIT_PD_DIST_REF];
    assign pd_pll      = active_pd[`PDUR_BIT_PD_PLL];

endmodule

// ===== verif/pdur_checker.sv
// Port checker of the power-down and update register block
`timescale 1ns/100ps

module pdur_checker
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Serial port
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdo,
    input wire logic sdo_oe,
    // Controls
    input wire logic pd_dist_all,
    input wire logic pd_clk_in,
    input wire logic pd_out_div,
    input wire logic pd_dist_ref,
    input wire logic pd_pll,
    input wire logic update_pending
);
    logic [4:0] pd;
    logic [3:0] since_rise;
    logic       sclk_d;

    // Gather the active controls
    assign pd = {pd_dist_all, pd_clk_in, pd_out_div, pd_dist_ref, pd_pll};

    // Cycles since the serial clock pin rose, saturating; edge seen from a delayed copy
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            sclk_d     <= 1'b0;
            since_rise <= 4'hf;
        end
        else
        begin
            sclk_d <= sclk;
            if (sclk && !sclk_d)
                since_rise <= 4'h0;
            else if (since_rise != 4'hf)
                since_rise <= since_rise + 4'h1;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // ****
    // Copy steps
    // ****
    sequence copy_edge;
        $rose(sclk) ##0 update_pending;
    endsequence
    sequence copy_done;
        ##[1:8] !update_pending;
    endsequence

    chk_copy_bound: assert property (copy_edge |-> copy_done)
        else $error("update not copied after serial clock rise");
    chk_pend_fall: assert property ($fell(update_pending) |-> since_rise <= 4'h8)
        else $error("update bit cleared without serial clock rise");
    chk_pend_hold: assert property (update_pending && since_rise == 4'hf |=> update_pending)
        else $error("update bit cleared while serial clock idle");
    chk_pd_cause: assert property (!$stable(pd) |-> $past(update_pending) && since_rise <= 4'h8)
        else $error("active controls changed without update");
    chk_reset_vals: assert property ($rose(resetn) |-> pd == 5'h00 && !update_pending)
        else $error("controls not cleared by reset");
    chk_oe_idle: assert property (cs_n [*5] |-> !sdo_oe)
        else $error("read output driven while deselected");
    chk_oe_start: assert property ($rose(sdo_oe) |-> !cs_n && since_rise <= 4'h8)
        else $error("read output enabled outside a frame");
    chk_sdo_hold: assert property (sdo_oe && sclk [*8] |-> $stable(sdo))
        else $error("read data moved while serial clock high");
endmodule

bind pdur_top pdur_checker pdur_checker_i
(
    .clk_sys(clk_sys), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe),
    .pd_dist_all(pd_dist_all), .pd_clk_in(pd_clk_in), .pd_out_div(pd_out_div),
    .pd_dist_ref(pd_dist_ref), .pd_pll(pd_pll), .update_pending(update_pending)
);

// ===== verif/pdur_host.sv
// Host model driving the serial control port
`timescale 1ns/100ps

module pdur_host
(
    // Clock and read data
    input wire logic clk_sys,
    input wire logic sdo,
    // Serial port drive
    output logic     sclk,
    output logic     cs_n,
    output logic     sdi
);
    localparam int HALF = 10;

    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end

    // Released data line keeps toggling so stale bits are never mistaken for data
    always @(posedge clk_sys)
        if (cs_n)
            sdi <= ~sdi;

    // One frame of n bits, read data shifted in before each rise from bit 16 on
    task automatic frame(input logic rnw, input logic [12:0] a, input logic [7:0] d,
                         input int n, output logic [7:0] rd);
        logic [23:0] w;
        w  = {rnw, 2'b00, a, d};
        rd = 8'h00;
        cs_n <= 1'b0;
        repeat (HALF) @(posedge clk_sys);
        for (int i = 0; i < n; i++)
        begin
            sdi <= w[23-i];
            repeat (HALF) @(posedge clk_sys);
            if (i >= 16)
                rd = {rd[6:0], sdo};
            sclk <= 1'b1;
            repeat (HALF) @(posedge clk_sys);
            sclk <= 1'b0;
        end
        repeat (HALF) @(posedge clk_sys);
        cs_n <= 1'b1;
        repeat (HALF) @(posedge clk_sys);
    endtask

    // Lone serial clock pulse that commits a staged update
    task automatic tick();
        sclk <= 1'b1;
        repeat (HALF) @(posedge clk_sys);
        sclk <= 1'b0;
        repeat (HALF) @(posedge clk_sys);
    endtask
endmodule

// ===== verif/testbench.sv
// Self-checking testbench of the power-down and update register block
`timescale 1ns/100ps

module testbench;
    logic        clk_sys, resetn, sclk, cs_n, sdi, sdo, sdo_oe, update_pending;
    logic        pd_dist_all, pd_clk_in, pd_out_div, pd_dist_ref, pd_pll;
    int          failures, num_checks;
    logic [7:0]  q[$];
    logic [7:0]  res, rd;
    logic [4:0]  prev;
    logic [31:0] seed;
    event        got;

    pdur_top pdur_top_i (.clk_sys(clk_sys), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
        .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .pd_dist_all(pd_dist_all), .pd_clk_in(pd_clk_in),
        .pd_out_div(pd_out_div), .pd_dist_ref(pd_dist_ref), .pd_pll(pd_pll),
        .update_pending(update_pending));
    // Host sees the inverse of the data pin while the block leaves it undriven
    pdur_host pdur_host_i (.clk_sys(clk_sys), .sdo(sdo_oe ? sdo : ~sdo), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi));

    // 20 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR result expected %h seen %h", exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Note expected pending bit and controls, then publish the outputs
    task automatic note(input logic [7:0] exp);
        q.push_back(exp);
        res = {2'b00, update_pending, pd_dist_all, pd_clk_in, pd_out_div, pd_dist_ref, pd_pll};
        -> got;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        pdur_host_i.frame(1'b0, a, d, 24, rd);
    endtask

    task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
        pdur_host_i.frame(1'b1, a, 8'h00, 24, rd);
        q.push_back(exp);
        res = rd;
        -> got;
        @(posedge clk_sys);
    endtask

    // Result watcher takes the oldest note
    initial
        forever
        begin
            @(got);
            check(res, q.pop_front());
        end

    // Watchdog
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        give_verdict();
    end

    initial
    begin
        resetn = 1'b0;
        failures = 0;
        num_checks = 0;
        seed = 32'h00000063;
        prev = 5'h00;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        note(8'h00);
        rd_chk(13'h0230, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 5; i++)
        begin
            wr(13'h0230, 8'he0 | (8'h01 << i));
            rd_chk(13'h0230, 8'h01 << i);
            wr(13'h0232, 8'hfe);
            pdur_host_i.tick();
            note({3'b000, prev});
            wr(13'h0232, 8'h01);
            note({3'b001, prev});
            pdur_host_i.tick();
            prev = 5'h01 << i;
            note({3'b000, prev});
        end
        $display("test single bits done");
        // Mid-run reset with controls and buffer set must clear both
        resetn <= 1'b0;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        prev = 5'h00;
        note(8'h00);
        rd_chk(13'h0230, 8'h00);
        $display("test mid-run reset done");
        repeat (4)
        begin
            seed = xs(seed);
            wr(13'h0230, seed[7:0]);
            pdur_host_i.tick();
            note({3'b000, prev});
            pdur_host_i.frame(1'b0, 13'h0230, ~seed[7:0], 20, rd);
            wr(13'h0232, 8'h01);
            pdur_host_i.tick();
            prev = seed[4:0];
            note({3'b000, prev});
            rd_chk(13'h0232, 8'h00);
        end
        rd_chk(13'h0100, 8'h00);
        $display("test random and abort done");
        give_verdict();
    end
endmodule
